// ===== hw/ddp_step.sv
`timescale 1ns/1ps
// ****************************************************
// One pointer step with circular wrap
// ****************************************************
module ddp_step (
	input  wire logic [15:0] ptr,
	input  wire logic        dec,
	input  wire logic        circ,
	input  wire logic [7:0]  len,
	output logic      [15:0] nxt
);
	import ddp_pkg::*;

	logic [15:0] len_a;
	logic [15:0] len_b;

	// Region end points from the length register
	assign len_a = REGION_A_BASE + {8'h00, len};
	assign len_b = REGION_B_BASE + {8'h00, len};

	// Wrap only on the end points, plain 16-bit step otherwise
	always_comb begin
		nxt = dec ? ptr - 16'h0001 : ptr + 16'h0001;
		if (circ) begin
			if (!dec && ptr == len_a)
				nxt = REGION_A_BASE;
			else if (!dec && ptr == len_b)
				nxt = REGION_B_BASE;
			else if (dec && ptr == REGION_A_BASE)
				nxt = len_a;
			else if (dec && ptr == REGION_B_BASE)
				nxt = len_b;
		end
	end
endmodule // ddp_step

// ===== hw/ddp_unit.sv
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - Direction bit set makes pointer increment instruction decrement that pointer.
// - Direction follows the physical pointer after select resolution.
// - Auto-update bit makes MOVX/MOVC through that pointer also update it.
// - Auto-update increments when direction bit is 0, decrements when 1.
// - Signature select sends pointer MOVC and programming accesses to signature; here signature_space is high whenever the bit is set, MOVX included.
// - Select bit 0 maps normal to pointer zero; 1 swaps mapping.
// - Redirect bit makes pointer one MOVX/MOVC use register B.
// - Redirect changes only the destination; index stays the accumulator.
// - Index disable makes indexed code read use the pointer alone.
// - Each pointer has its own circular enable bit.
// - Regions are 0000H..length and 0100H..100H plus length.
// - Increment at region end wraps to region base.
// - Decrement at region base wraps to region end.
// - Wrap applies to explicit increments and automatic updates alike.
// - Elsewhere pointers step normally even with circular mode on.
// - Wrap depends only on pointer value, not on which pointer.
// - Bit 2 of pointer configuration reads as zero.
// - Prefixed instructions use the inverted select, except indirect jump.
module ddp_unit (
	input  wire logic                            mclk,
	input  wire logic                            reset_n,
	// Wishbone classic slave
	input  wire logic                            wb_cyc_i,
	input  wire logic                            wb_stb_i,
	input  wire logic                            wb_we_i,
	input  wire logic [ddp_pkg::BUS_ADDR_W-1:0]  wb_adr_i,
	input  wire logic [7:0]                      wb_dat_i,
	input  wire logic                            wb_sel_i,
	output logic      [7:0]                      wb_dat_o,
	output logic                                 wb_ack_o,
	output logic                                 wb_err_o,
	// Execute stage request
	input  wire logic                            op_valid,
	input  wire ddp_pkg::ddp_op_e                op_kind,
	input  wire logic                            op_alternate,
	input  wire logic                            op_jump,
	input  wire logic [7:0]                      acc_in,
	// Address and routing to the memory side
	output logic      [15:0]                     mem_addr,
	output logic                                 use_b_reg,
	output logic                                 signature_space,
	output logic                                 ptr_is_one,
	output logic      [15:0]                     ptr0_out,
	output logic      [15:0]                     ptr1_out
);
	import ddp_pkg::*;

	// ****************************************************
	// State
	// ****************************************************
	logic [7:0]  pcf_q, pcf_d;
	logic [7:0]  spc_q, spc_d;
	logic [7:0]  clen_q, clen_d;
	logic [15:0] ptr0_q, ptr0_d;
	logic [15:0] ptr1_q, ptr1_d;
	ddp_bus_e    bus_q, bus_d;
	logic [7:0]  rdat_q, rdat_d;
	logic        err_q, err_d;
	logic [15:0] maddr_q, maddr_d;
	logic        useb_q, useb_d;
	logic        sig_q, sig_d;
	logic        sel1_q, sel1_d;

	logic        sel_one;
	logic        sel_dir;
	logic        sel_circ;
	logic [15:0] sel_ptr;
	logic [15:0] sel_next;
	logic        do_step;
	logic        bus_req;
	logic        bus_wr;
	logic        hit;

	// ****************************************************
	// Pointer resolution
	// ****************************************************
	// Physical pointer from select bit and prefix
	always_comb begin
		sel_one = pcf_q[PCF_POINTER_SELECT] ^ (op_alternate & ~op_jump);
		sel_dir = sel_one ? pcf_q[PCF_PTR1_DIRECTION]
			: pcf_q[PCF_PTR0_DIRECTION];
		sel_circ = sel_one ? spc_q[SPC_PTR1_CIRC_ENABLE]
			: spc_q[SPC_PTR0_CIRC_ENABLE];
		sel_ptr = sel_one ? ptr1_q : ptr0_q;
	end

	// Step unit shared by both pointers
	ddp_step u_step (
		.ptr  (sel_ptr),
		.dec  (sel_dir),
		.circ (sel_circ),
		.len  (clen_q),
		.nxt  (sel_next)
	);

	// Decide whether the selected pointer moves
	always_comb begin
		do_step = 1'b0;
		if (op_valid) begin
			case (op_kind)
				DDP_OP_INC:  do_step = 1'b1;
				DDP_OP_MOVX,
				DDP_OP_MOVC: do_step = sel_one ? pcf_q[PCF_PTR1_AUTO_UPDATE]
					: pcf_q[PCF_PTR0_AUTO_UPDATE];
				default:     do_step = 1'b0;
			endcase
		end
	end

	// ****************************************************
	// Wishbone slave
	// ****************************************************
	assign bus_req = wb_cyc_i & wb_stb_i & (bus_q == DDP_BUS_IDLE);
	assign bus_wr  = bus_req & wb_we_i & wb_sel_i;

	// Address decode
	always_comb begin
		case (wb_adr_i)
			ADDR_POINTER_CONFIG, ADDR_CIRCULAR_LENGTH, ADDR_SIGNAL_PROC_CFG,
			ADDR_PTR0_LO, ADDR_PTR0_HI, ADDR_PTR1_LO, ADDR_PTR1_HI:
				hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Register and pointer next values; execute has priority over bus
	always_comb begin
		pcf_d  = pcf_q;
		spc_d  = spc_q;
		clen_d = clen_q;
		ptr0_d = ptr0_q;
		ptr1_d = ptr1_q;
		if (bus_wr && hit) begin
			case (wb_adr_i)
				ADDR_POINTER_CONFIG:  pcf_d  = wb_dat_i & PCF_WRITE_MASK;
				ADDR_CIRCULAR_LENGTH: clen_d = wb_dat_i;
				ADDR_SIGNAL_PROC_CFG: spc_d  = wb_dat_i;
				ADDR_PTR0_LO:         ptr0_d[7:0]  = wb_dat_i;
				ADDR_PTR0_HI:         ptr0_d[15:8] = wb_dat_i;
				ADDR_PTR1_LO:         ptr1_d[7:0]  = wb_dat_i;
				ADDR_PTR1_HI:         ptr1_d[15:8] = wb_dat_i;
				default:              pcf_d  = pcf_q;
			endcase
		end
		if (do_step) begin
			if (sel_one)
				ptr1_d = sel_next;
			else
				ptr0_d = sel_next;
		end
	end

	// Bus answer: ack one cycle after request
	always_comb begin
		bus_d  = DDP_BUS_IDLE;
		rdat_d = rdat_q;
		err_d  = 1'b0;
		case (bus_q)
			DDP_BUS_IDLE: begin
				if (bus_req) begin
					bus_d = DDP_BUS_ACK;
					err_d = ~hit;
					case (wb_adr_i)
						ADDR_POINTER_CONFIG:  rdat_d = pcf_q & PCF_WRITE_MASK;
						ADDR_CIRCULAR_LENGTH: rdat_d = clen_q;
						ADDR_SIGNAL_PROC_CFG: rdat_d = spc_q;
						ADDR_PTR0_LO:         rdat_d = ptr0_q[7:0];
						ADDR_PTR0_HI:         rdat_d = ptr0_q[15:8];
						ADDR_PTR1_LO:         rdat_d = ptr1_q[7:0];
						ADDR_PTR1_HI:         rdat_d = ptr1_q[15:8];
						default:              rdat_d = 8'h00;
					endcase
				end
			end
			DDP_BUS_ACK: bus_d = DDP_BUS_IDLE;
			default:     bus_d = DDP_BUS_IDLE;
		endcase
	end

	// ****************************************************
	// Memory-side address and routing
	// ****************************************************
	always_comb begin
		maddr_d = maddr_q;
		useb_d  = useb_q;
		sig_d   = sig_q;
		sel1_d  = sel1_q;
		if (op_valid && (op_kind == DDP_OP_MOVX || op_kind == DDP_OP_MOVC)) begin
			sel1_d = sel_one;
			useb_d = sel_one & spc_q[SPC_REDIRECT_TO_B];
			sig_d  = (op_kind == DDP_OP_MOVC)
				& pcf_q[PCF_SIGNATURE_SELECT];
			if (op_kind == DDP_OP_MOVC && !spc_q[SPC_INDEX_DISABLE])
				maddr_d = sel_ptr + {8'h00, acc_in};
			else
				maddr_d = sel_ptr;
		end
	end

	// ****************************************************
	// Registers
	// ****************************************************
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pcf_q   <= PCF_RESET;
			spc_q   <= SPC_RESET;
			clen_q  <= CLEN_RESET;
			ptr0_q  <= PTR_RESET;
			ptr1_q  <= PTR_RESET;
			bus_q   <= DDP_BUS_IDLE;
			rdat_q  <= 8'h00;
			err_q   <= 1'b0;
			maddr_q <= PTR_RESET;
			useb_q  <= 1'b0;
			sig_q   <= 1'b0;
			sel1_q  <= 1'b0;
		end else begin
			pcf_q   <= pcf_d;
			spc_q   <= spc_d;
			clen_q  <= clen_d;
			ptr0_q  <= ptr0_d;
			ptr1_q  <= ptr1_d;
			bus_q   <= bus_d;
			rdat_q  <= rdat_d;
			err_q   <= err_d;
			maddr_q <= maddr_d;
			useb_q  <= useb_d;
			sig_q   <= sig_d;
			sel1_q  <= sel1_d;
		end
	end

	// Outputs
	assign wb_dat_o        = rdat_q;
	assign wb_ack_o        = (bus_q == DDP_BUS_ACK) & ~err_q;
	assign wb_err_o        = (bus_q == DDP_BUS_ACK) & err_q;
	assign mem_addr        = maddr_q;
	assign use_b_reg       = useb_q;
	assign signature_space = sig_q | pcf_q[PCF_SIGNATURE_SELECT];
	assign ptr_is_one      = sel1_q;
	assign ptr0_out        = ptr0_q;
	assign ptr1_out        = ptr1_q;
endmodule // ddp_unit

// ===== inc/ddp_pkg.sv
package ddp_pkg;
	// ****************************************************
	// Register map (byte addresses)
	// ****************************************************
	localparam logic [7:0] ADDR_POINTER_CONFIG   = 8'ha2;
	localparam logic [7:0] ADDR_CIRCULAR_LENGTH  = 8'he3;
	localparam logic [7:0] ADDR_SIGNAL_PROC_CFG  = 8'he2;
	localparam logic [7:0] ADDR_PTR0_LO          = 8'h82;
	localparam logic [7:0] ADDR_PTR0_HI          = 8'h83;
	localparam logic [7:0] ADDR_PTR1_LO          = 8'h84;
	localparam logic [7:0] ADDR_PTR1_HI          = 8'h85;
	localparam int         BUS_ADDR_W            = 8;

	// ****************************************************
	// pointer_config fields
	// ****************************************************
	localparam int PCF_PTR1_AUTO_UPDATE = 7;
	localparam int PCF_PTR0_AUTO_UPDATE = 6;
	localparam int PCF_PTR1_DIRECTION   = 5;
	localparam int PCF_PTR0_DIRECTION   = 4;
	localparam int PCF_SIGNATURE_SELECT = 3;
	localparam int PCF_POINTER_SELECT   = 0;
	localparam logic [7:0] PCF_WRITE_MASK = 8'hf9;

	// ****************************************************
	// signal_processing_config fields
	// ****************************************************
	localparam int SPC_REDIRECT_TO_B    = 0;
	localparam int SPC_INDEX_DISABLE    = 1;
	localparam int SPC_PTR0_CIRC_ENABLE = 2;
	localparam int SPC_PTR1_CIRC_ENABLE = 3;

	// ****************************************************
	// Reset values and region bases
	// ****************************************************
	localparam logic [7:0]  PCF_RESET      = 8'h00;
	localparam logic [7:0]  SPC_RESET      = 8'h00;
	localparam logic [7:0]  CLEN_RESET     = 8'h00;
	localparam logic [15:0] PTR_RESET      = 16'h0000;
	localparam logic [15:0] REGION_A_BASE  = 16'h0000;
	localparam logic [15:0] REGION_B_BASE  = 16'h0100;

	// Pointer operations requested by the execute stage
	typedef enum logic [1:0] {
		DDP_OP_NONE = 2'b00,
		DDP_OP_INC  = 2'b01,
		DDP_OP_MOVX = 2'b11,
		DDP_OP_MOVC = 2'b10
	} ddp_op_e;

	// Bus slave states
	typedef enum logic [0:0] {
		DDP_BUS_IDLE = 1'b0,
		DDP_BUS_ACK  = 1'b1
	} ddp_bus_e;
endpackage

// ===== verif/ddp_exec_model.sv
`timescale 1ns/1ps
// ****
// Execute stage stand-in
// ****
module ddp_exec_model
	import ddp_pkg::*;
(
	input  wire logic		mclk,
	output logic			op_valid,
	output ddp_pkg::ddp_op_e	op_kind,
	output logic			op_alternate,
	output logic			op_jump,
	output logic [7:0]		acc_in
);
	// Idle outputs from time zero
	initial begin
		op_valid = 0;
		op_kind = DDP_OP_NONE;
		op_alternate = 0;
		op_jump = 0;
		acc_in = 8'h00;
	end
	// One-cycle pulse, returns where results are settled
	task automatic issue(input ddp_op_e k, input logic a,
		input logic [7:0] x);
		@(posedge mclk);
		op_valid <= 1;
		op_kind <= k;
		op_alternate <= a;
		acc_in <= x;
		@(posedge mclk);
		op_valid <= 0;
		op_kind <= DDP_OP_NONE;
		@(negedge mclk);
	endtask
endmodule // ddp_exec_model

// ===== verif/ddp_unit_chk.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module ddp_unit_chk
	import ddp_pkg::*;
(
	input wire logic			mclk,
	input wire logic			reset_n,
	input wire logic			wb_cyc_i,
	input wire logic			wb_stb_i,
	input wire logic			wb_we_i,
	input wire logic [BUS_ADDR_W-1:0]	wb_adr_i,
	input wire logic [7:0]			wb_dat_i,
	input wire logic			wb_sel_i,
	input wire logic [7:0]			wb_dat_o,
	input wire logic			wb_ack_o,
	input wire ddp_pkg::ddp_op_e		op_kind,
	input wire logic			op_valid,
	input wire logic			op_alternate,
	input wire logic			op_jump,
	input wire logic [7:0]			acc_in,
	input wire logic [15:0]			mem_addr,
	input wire logic			use_b_reg,
	input wire logic			signature_space,
	input wire logic			ptr_is_one,
	input wire logic [15:0]			ptr0_out,
	input wire logic [15:0]			ptr1_out
);
	logic [7:0]	pcf_q, pcf_d, spc_q, spc_d, len_q, len_d;
	logic		t1, m, d, c, au, go;
	logic [15:0]	p, nx, ea;
	// Step with circular wrap at either region
	function automatic logic [15:0] stp(logic [15:0] v, logic dn,
		logic ce, logic [7:0] l);
		if (ce && !dn && (v == {8'h00, l} || v == {8'h01, l}))
			return {v[15:8], 8'h00};
		if (ce && dn && (v == 16'h0000 || v == 16'h0100))
			return {v[15:8], l};
		return dn ? v - 16'h0001 : v + 16'h0001;
	endfunction
	// Shadow of configuration writes
	always_comb begin
		pcf_d = pcf_q;
		spc_d = spc_q;
		len_d = len_q;
		if (wb_ack_o && wb_we_i && wb_sel_i) begin
			if (wb_adr_i == ADDR_POINTER_CONFIG)
				pcf_d = wb_dat_i & PCF_WRITE_MASK;
			if (wb_adr_i == ADDR_SIGNAL_PROC_CFG)
				spc_d = wb_dat_i;
			if (wb_adr_i == ADDR_CIRCULAR_LENGTH)
				len_d = wb_dat_i;
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pcf_q <= 8'h00;
			spc_q <= 8'h00;
			len_q <= 8'h00;
		end else begin
			pcf_q <= pcf_d;
			spc_q <= spc_d;
			len_q <= len_d;
		end
	end
	// Expected pointer and address for the current op
	always_comb begin
		go = op_valid && !(wb_cyc_i && wb_stb_i);
		t1 = pcf_q[PCF_POINTER_SELECT] ^ (op_alternate & ~op_jump);
		p = t1 ? ptr1_out : ptr0_out;
		d = pcf_q[t1 ? PCF_PTR1_DIRECTION : PCF_PTR0_DIRECTION];
		c = spc_q[t1 ? SPC_PTR1_CIRC_ENABLE : SPC_PTR0_CIRC_ENABLE];
		au = pcf_q[t1 ? PCF_PTR1_AUTO_UPDATE : PCF_PTR0_AUTO_UPDATE];
		m = op_kind == DDP_OP_MOVX || op_kind == DDP_OP_MOVC;
		ea = p;
		if (op_kind == DDP_OP_MOVC && !spc_q[SPC_INDEX_DISABLE])
			ea = p + {8'h00, acc_in};
		nx = p;
		if (op_kind == DDP_OP_INC || (m && au))
			nx = stp(p, d, c, len_q);
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	ptr0_step_a: assert property (go && !t1 |=>
		ptr0_out == $past(nx) && $stable(ptr1_out)) else $error("ptr0 step");
	ptr1_step_a: assert property (go && t1 |=>
		ptr1_out == $past(nx) && $stable(ptr0_out)) else $error("ptr1 step");
	addr_index_a: assert property (go && m |=>
		mem_addr == $past(ea)) else $error("access address");
	redirect_b_a: assert property (go && m |=>
		use_b_reg == $past(t1 && spc_q[SPC_REDIRECT_TO_B]))
		else $error("b redirect");
	which_ptr_a: assert property (go && m |=>
		ptr_is_one == $past(t1)) else $error("pointer choice");
	sig_space_a: assert property (go && op_kind == DDP_OP_MOVC |=>
		signature_space == $past(pcf_q[PCF_SIGNATURE_SELECT]))
		else $error("signature space");
	zero_bits_a: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i == ADDR_POINTER_CONFIG |-> wb_dat_o[2:1] == 2'b00)
		else $error("config bits 2..1");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
endmodule // ddp_unit_chk

bind ddp_unit ddp_unit_chk u_chk (.mclk(mclk), .reset_n(reset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_kind(op_kind),
	.op_valid(op_valid), .op_alternate(op_alternate), .op_jump(op_jump),
	.acc_in(acc_in),
	.mem_addr(mem_addr), .use_b_reg(use_b_reg), .ptr_is_one(ptr_is_one),
	.signature_space(signature_space), .ptr0_out(ptr0_out),
	.ptr1_out(ptr1_out));

// ===== verif/ddp_unit_test.sv
`timescale 1ns/1ps
module ddp_unit_test;
	import ddp_pkg::*;
	logic		mclk, reset_n, cyc, stb, we, sel, ack, err;
	logic		ub, ss, p1, va, al, jp, t, re;
	logic [7:0]	adr, wd, rd, rq, ac;
	logic [15:0]	ma, q0, q1, e;
	ddp_op_e	kd;
	int		fails, checks, cyc_n;
	logic [15:0]	cp[8] = '{16'h001f, 16'h011f, 16'h0000, 16'h0100,
				16'h0020, 16'h00ff, 16'h0120, 16'hffff};
	logic [15:0]	cx[8] = '{16'h0000, 16'h0100, 16'h001f, 16'h011f,
				16'h0021, 16'h0100, 16'h011f, 16'h0000};
	logic [7:0]	dl = 8'b0100_1100;
	logic		bs = 1'b1;
	ddp_unit u_dut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd),
		.wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err),
		.op_valid(va), .op_kind(kd), .op_alternate(al), .op_jump(jp),
		.acc_in(ac), .mem_addr(ma), .use_b_reg(ub),
		.signature_space(ss), .ptr_is_one(p1), .ptr0_out(q0),
		.ptr1_out(q1));
	ddp_exec_model u_exe (.mclk(mclk), .op_valid(va), .op_kind(kd),
		.op_alternate(al), .op_jump(jp), .acc_in(ac));
	// Clock and cycle ceiling
	initial mclk = 0;
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			fails++;
			wrap_up;
		end
	end
	// One classic bus cycle, held until ack or err; ceiling ends a hang
	task automatic wb(input logic w, input logic [7:0] a, x);
		@(posedge mclk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= bs;
		adr <= a;
		wd <= x;
		@(posedge mclk);
		while (ack !== 1 && err !== 1) begin
			@(posedge mclk);
		end
		rq = rd;
		re = err;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic chk(input logic [15:0] g, x);
		checks++;
		if (g !== x) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, g, x);
		end
	endtask
	task automatic setp(input logic [15:0] v);
		wb(1, ADDR_PTR0_LO, v[7:0]);
		wb(1, ADDR_PTR0_HI, v[15:8]);
		wb(1, ADDR_PTR1_LO, v[7:0]);
		wb(1, ADDR_PTR1_HI, v[15:8]);
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		{reset_n, cyc, stb, we, sel, adr, wd} = '0;
		sel = 1;
		repeat (4) @(posedge mclk);
		reset_n <= 1;
		wb(0, ADDR_POINTER_CONFIG, 0);
		chk(rq, 0);
		wb(1, ADDR_POINTER_CONFIG, 8'hff);
		wb(0, ADDR_POINTER_CONFIG, 0);
		chk(rq, 16'h00f9);
		wb(1, ADDR_POINTER_CONFIG, rq + 8'h01);
		wb(0, ADDR_POINTER_CONFIG, 0);
		chk(rq, 16'h00f8);
		wb(1, ADDR_CIRCULAR_LENGTH, 8'h5a);
		bs = 1'b0;
		wb(1, ADDR_CIRCULAR_LENGTH, 8'h33);
		bs = 1'b1;
		wb(0, ADDR_CIRCULAR_LENGTH, 0);
		chk(rq, 16'h005a);
		wb(1, ADDR_PTR1_HI, 8'hc3);
		wb(0, ADDR_PTR1_HI, 0);
		chk(rq, 16'h00c3);
		wb(0, 8'h10, 0);
		chk(re, 1);
		$display("registers done");
		for (int i = 0; i < 16; i++) begin
			t = i[0] ^ i[1];
			wb(1, ADDR_POINTER_CONFIG, {2'b00, i[3:2], 3'b000, i[0]});
			setp(16'h1234);
			u_exe.issue(DDP_OP_INC, i[1], 0);
			e = (t ? i[3] : i[2]) ? 16'h1233 : 16'h1235;
			chk(q0, t ? 16'h1234 : e);
			chk(q1, t ? e : 16'h1234);
		end
		$display("step direction done");
		for (int i = 0; i < 16; i++) begin
			wb(1, ADDR_POINTER_CONFIG, {i[0], i[0], i[1], i[1], i[1], 3'h0});
			wb(1, ADDR_SIGNAL_PROC_CFG, {6'h00, i[2] ^ i[0], i[1]});
			setp(16'h20ff);
			u_exe.issue(i[3] ? DDP_OP_MOVC : DDP_OP_MOVX, i[2], 8'h05);
			chk(ma, i[3] && !(i[2] ^ i[0]) ? 16'h2104 : 16'h20ff);
			chk(p1, i[2]);
			chk(ub, i[1] & i[2]);
			chk(ss, i[1]);
			e = !i[0] ? 16'h20ff : i[1] ? 16'h20fe : 16'h2100;
			chk(i[2] ? q1 : q0, e);
		end
		$display("auto update done");
		wb(1, ADDR_CIRCULAR_LENGTH, 8'h1f);
		wb(1, ADDR_SIGNAL_PROC_CFG, 8'h0c);
		for (int i = 0; i < 8; i++) begin
			wb(1, ADDR_POINTER_CONFIG, {2'b11, dl[i], dl[i], 4'h0});
			setp(cp[i]);
			u_exe.issue(i[1] ? DDP_OP_MOVX : DDP_OP_INC, i[0], 0);
			chk(i[0] ? q1 : q0, cx[i]);
		end
		wb(1, ADDR_SIGNAL_PROC_CFG, 8'h04);
		wb(1, ADDR_POINTER_CONFIG, 8'h00);
		setp(16'h001f);
		u_exe.issue(DDP_OP_INC, 1, 0);
		u_exe.issue(DDP_OP_INC, 0, 0);
		chk(q1, 16'h0020);
		chk(q0, 16'h0000);
		$display("circular done");
		wrap_up;
	end
endmodule // ddp_unit_test
